/* File: pkg/rlt_pkg.sv */
// Contract
// RULE1 - termination field bits 4:3, codes 00/01, reset 00
// RULE2 - bit 2 picks bridge speed, 0=100k
// RULE3 - host sets hotplug sleep inhibit before 400k
// RULE4 - data swing bits 7:5, eight percentage codes
// RULE5 - clock swing bits 4:2, 000 follows rate
// RULE6 - tap weight bits 1:0, 00 none, 01 2dB
// RULE7 - tap follows pin; gated writes while config low
// RULE8 - data fixed gain bits 5:3, eight steps
// RULE9 - clock fixed gain bits 2:1, 11 reserved
// RULE10 - per-lane timing pulse bits 7:4
// RULE11 - load bit high passes settings into lane
// RULE12 - load low holds last settings per lane
// RULE13 - mismatch status bits 7:4, read only, reset zero
// RULE14 - search in progress bits 3:0, read only
// RULE15 - lane values change only on commit bit
// RULE16 - fixed gains used only when adaptive off
// RULE17 - reserved bits ignore writes, read reset value
// RULE18 - status bits ignore writes, hardware wins
package rlt_pkg;
	localparam int LANES = 4;
	localparam int VSET_W = 32;
	// bus address of the management port; value is arbitrary
	localparam logic [6:0] DEV_ADDR = 7'h2C;

	localparam logic [7:0] OFS_MODE_CTRL = 8'h0A;
	localparam logic [7:0] OFS_LINK_MISC = 8'h0B;
	localparam logic [7:0] OFS_SWING_TAP = 8'h0C;
	localparam logic [7:0] OFS_FIXED_GAIN = 8'h0D;
	localparam logic [7:0] OFS_VER_LOAD = 8'h0E;
	localparam logic [7:0] OFS_VER_STATUS = 8'h0F;

	// mode control fields
	localparam int ADAPT_BIT = 5;
	localparam int COMMIT_BIT = 2;
	localparam logic ADAPT_RST = 1'b1;
	// link misc fields
	localparam int TERM_LSB = 3;
	localparam int SPEED_BIT = 2;
	localparam logic [1:0] TERM_RST = 2'h0;
	localparam logic SPEED_RST = 1'b0;
	// swing and tap fields
	localparam int DSWING_LSB = 5;
	localparam int CSWING_LSB = 2;
	localparam int TAP_LSB = 0;
	localparam logic [2:0] DSWING_RST = 3'h0;
	localparam logic [2:0] CSWING_RST = 3'h0;
	localparam logic [1:0] TAP_RST = 2'h0;
	// fixed gain fields
	localparam int DGAIN_LSB = 3;
	localparam int CGAIN_LSB = 1;
	localparam logic [2:0] DGAIN_RST = 3'h0;
	localparam logic [1:0] CGAIN_RST = 2'h0;
	localparam logic GAIN_RSVD_BIT0 = 1'b1;
	// verifier fields
	localparam int SYNC_LSB = 4;
	localparam int LOAD_LSB = 0;
	localparam int MISMATCH_LSB = 4;
	localparam int SEARCH_LSB = 0;
	localparam logic [3:0] LANE_RST = 4'h0;

	typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RACK, ST_TX, ST_TACK} rlt_state_t;
endpackage

/* File: verilog/rlt_lane_latch.sv */
module rlt_lane_latch
	import rlt_pkg::*;
(
	// clock and reset
	input wire logic CLK_I,
	input wire logic RESETN_I,
	// settings source and per-lane load
	input wire logic [VSET_W-1:0] settings_i,
	input wire logic [LANES-1:0] load_i,
	// settings held by each lane
	output logic [LANES*VSET_W-1:0] lane_o
);
	logic [LANES*VSET_W-1:0] lane_q;
	logic [LANES*VSET_W-1:0] lane_d;

	always_comb begin
		lane_d = lane_q; // RULE12
		for (int i = 0; i < LANES; i++) begin
			if (load_i[i]) begin
				lane_d[i*VSET_W +: VSET_W] = settings_i; // RULE11
			end
		end
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			lane_q <= '0;
		end else begin
			lane_q <= lane_d;
		end
	end

	assign lane_o = lane_q;
endmodule

/* File: verilog/rlt_mgmt_slave.sv */
module rlt_mgmt_slave
	import rlt_pkg::*;
(
	// clock and reset
	input wire logic CLK_I,
	input wire logic RESETN_I,
	// two-wire pins, open drain
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	// register side
	output logic wr_stb_o,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o,
	input wire logic [7:0] rdata_i
);
	rlt_state_t state_q, state_d;
	logic scl_q, sda_q, oe_q, oe_d, rw_q, rw_d;
	logic addr_ph_q, addr_ph_d, ptr_ph_q, ptr_ph_d, nack_q, nack_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
	logic scl_rise, scl_fall, start_c, stop_c;

	assign scl_rise = scl_i & ~scl_q;
	assign scl_fall = ~scl_i & scl_q;
	assign start_c = scl_i & scl_q & sda_q & ~sda_i;
	assign stop_c = scl_i & scl_q & ~sda_q & sda_i;

	always_comb begin
		state_d = state_q;
		oe_d = oe_q;
		rw_d = rw_q;
		addr_ph_d = addr_ph_q;
		ptr_ph_d = ptr_ph_q;
		nack_d = nack_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		ptr_d = ptr_q;
		wr_stb_o = 1'b0;
		if (start_c) begin
			state_d = ST_RX;
			cnt_d = 4'h0;
			addr_ph_d = 1'b1;
			oe_d = 1'b0;
		end else if (stop_c) begin
			state_d = ST_IDLE;
			oe_d = 1'b0;
		end else begin
			case (state_q)
				ST_RX: begin
					if (scl_rise) begin
						sh_d = {sh_q[6:0], sda_i};
						cnt_d = cnt_q + 4'h1;
					end else if (scl_fall && cnt_q == 4'h8) begin
						oe_d = 1'b1;
						state_d = ST_RACK;
						if (addr_ph_q) begin
							addr_ph_d = 1'b0;
							rw_d = sh_q[0];
							ptr_ph_d = ~sh_q[0];
							if (sh_q[7:1] != DEV_ADDR) begin
								oe_d = 1'b0;
								state_d = ST_IDLE;
							end
						end else if (ptr_ph_q) begin
							ptr_d = sh_q;
							ptr_ph_d = 1'b0;
						end else begin
							wr_stb_o = 1'b1;
							ptr_d = ptr_q + 8'h01;
						end
					end
				end
				ST_RACK: begin
					if (scl_fall) begin
						cnt_d = 4'h0;
						if (rw_q) begin
							sh_d = rdata_i;
							oe_d = ~rdata_i[7];
							state_d = ST_TX;
						end else begin
							oe_d = 1'b0;
							state_d = ST_RX;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (cnt_q == 4'h7) begin
							oe_d = 1'b0;
							ptr_d = ptr_q + 8'h01;
							state_d = ST_TACK;
						end else begin
							sh_d = {sh_q[6:0], 1'b0};
							oe_d = ~sh_q[6];
							cnt_d = cnt_q + 4'h1;
						end
					end
				end
				ST_TACK: begin
					if (scl_rise) begin
						nack_d = sda_i;
					end else if (scl_fall) begin
						cnt_d = 4'h0;
						if (nack_q) begin
							state_d = ST_IDLE;
						end else begin
							sh_d = rdata_i;
							oe_d = ~rdata_i[7];
							state_d = ST_TX;
						end
					end
				end
				default: begin
					state_d = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			state_q <= ST_IDLE;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
			oe_q <= 1'b0;
			rw_q <= 1'b0;
			addr_ph_q <= 1'b0;
			ptr_ph_q <= 1'b0;
			nack_q <= 1'b0;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			ptr_q <= 8'h00;
		end else begin
			state_q <= state_d;
			scl_q <= scl_i;
			sda_q <= sda_i;
			oe_q <= oe_d;
			rw_q <= rw_d;
			addr_ph_q <= addr_ph_d;
			ptr_ph_q <= ptr_ph_d;
			nack_q <= nack_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			ptr_q <= ptr_d;
		end
	end

	// open drain: the pin is only ever pulled low
	assign sda_o = 1'b0;
	assign sda_oe_o = oe_q;
	assign addr_o = ptr_q;
	assign wdata_o = sh_q;
endmodule

/* File: verilog/rlt_csr_top.sv */
module rlt_csr_top
	import rlt_pkg::*;
(
	// clock and reset
	input wire logic CLK_I,
	input wire logic RESETN_I,
	// management port pins
	input wire logic SCL_I,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_O,
	// configuration straps
	input wire logic CFG_EN_I,
	input wire logic [1:0] PRE_SEL_I,
	// verifier lane status and settings
	input wire logic [LANES-1:0] LANE_SYNC_I,
	input wire logic [LANES-1:0] LANE_MISMATCH_I,
	input wire logic [LANES-1:0] LANE_SEARCH_I,
	input wire logic [VSET_W-1:0] VERIFIER_SETTINGS_I,
	output logic [LANES*VSET_W-1:0] LANE_SETTINGS_O,
	// lane tuning outputs; all but bridge speed are committed
	output logic [1:0] TX_TERM_O,
	output logic BRIDGE_SPEED_O,
	output logic [2:0] DATA_SWING_O,
	output logic [2:0] CLOCK_SWING_O,
	output logic [1:0] TAP_WEIGHT_O,
	output logic ADAPTIVE_GAIN_O,
	output logic [2:0] DATA_GAIN_O,
	output logic [1:0] CLOCK_GAIN_O
);
	logic wr_stb;
	logic [7:0] bus_addr, bus_wdata, bus_rdata;

	// stored register fields
	logic adapt_q, adapt_d, speed_q, speed_d;
	logic [1:0] term_q, term_d, tap_q, tap_d, cgain_q, cgain_d;
	logic [2:0] dswing_q, dswing_d, cswing_q, cswing_d, dgain_q, dgain_d;
	logic [LANES-1:0] load_q, load_d, sync_q, sync_d;
	logic [LANES-1:0] mism_q, mism_d, search_q, search_d;
	logic commit;

	// committed copies driving the lanes
	logic [1:0] a_term_q, a_term_d, a_tap_q, a_tap_d, a_cgain_q, a_cgain_d;
	logic [2:0] a_dsw_q, a_dsw_d, a_csw_q, a_csw_d, a_dgain_q, a_dgain_d;
	logic a_adapt_q, a_adapt_d;

	rlt_mgmt_slave u_slave (
		.CLK_I(CLK_I),
		.RESETN_I(RESETN_I),
		.scl_i(SCL_I),
		.sda_i(SDA_I),
		.sda_o(SDA_O),
		.sda_oe_o(SDA_OE_O),
		.wr_stb_o(wr_stb),
		.addr_o(bus_addr),
		.wdata_o(bus_wdata),
		.rdata_i(bus_rdata)
	);

	rlt_lane_latch u_latch (
		.CLK_I(CLK_I),
		.RESETN_I(RESETN_I),
		.settings_i(VERIFIER_SETTINGS_I),
		.load_i(load_q),
		.lane_o(LANE_SETTINGS_O)
	);

	function automatic logic wr_hit(input logic stb, input logic [7:0] a, input logic [7:0] ofs);
		wr_hit = stb && (a == ofs);
	endfunction

	// read image; unlisted and reserved bits read as their reset value
	function automatic logic [7:0] rd_mux(input logic [7:0] a);
		rd_mux = 8'h00;
		case (a)
			OFS_MODE_CTRL: rd_mux[ADAPT_BIT] = adapt_q;
			OFS_LINK_MISC: begin
				rd_mux[TERM_LSB +: 2] = term_q;
				rd_mux[SPEED_BIT] = speed_q;
			end
			OFS_SWING_TAP: rd_mux = {dswing_q, cswing_q, tap_q};
			OFS_FIXED_GAIN: begin
				rd_mux[DGAIN_LSB +: 3] = dgain_q;
				rd_mux[CGAIN_LSB +: 2] = cgain_q;
				rd_mux[0] = GAIN_RSVD_BIT0; // RULE17
			end
			OFS_VER_LOAD: begin
				rd_mux[SYNC_LSB +: 4] = sync_q;
				rd_mux[LOAD_LSB +: 4] = load_q;
			end
			OFS_VER_STATUS: begin
				rd_mux[MISMATCH_LSB +: 4] = mism_q;
				rd_mux[SEARCH_LSB +: 4] = search_q;
			end
			default: rd_mux = 8'h00;
		endcase
	endfunction

	assign bus_rdata = rd_mux(bus_addr);
	// apply bit is self clearing: it is never stored, so it reads zero
	assign commit = wr_hit(wr_stb, bus_addr, OFS_MODE_CTRL) && bus_wdata[COMMIT_BIT]; // RULE15

	always_comb begin
		adapt_d = adapt_q;
		term_d = term_q;
		speed_d = speed_q;
		dswing_d = dswing_q;
		cswing_d = cswing_q;
		tap_d = tap_q;
		dgain_d = dgain_q;
		cgain_d = cgain_q;
		load_d = load_q;
		if (wr_hit(wr_stb, bus_addr, OFS_MODE_CTRL) && CFG_EN_I) begin
			adapt_d = bus_wdata[ADAPT_BIT]; // RULE16
		end
		if (wr_hit(wr_stb, bus_addr, OFS_LINK_MISC)) begin
			speed_d = bus_wdata[SPEED_BIT]; // RULE2
			if (CFG_EN_I) begin
				term_d = bus_wdata[TERM_LSB +: 2]; // RULE1 RULE7
			end
		end
		if (wr_hit(wr_stb, bus_addr, OFS_SWING_TAP)) begin
			dswing_d = bus_wdata[DSWING_LSB +: 3]; // RULE4
			cswing_d = bus_wdata[CSWING_LSB +: 3]; // RULE5
			if (CFG_EN_I) begin
				tap_d = bus_wdata[TAP_LSB +: 2]; // RULE6
			end
		end
		// strap wins while host configuration is off
		if (!CFG_EN_I) begin
			tap_d = PRE_SEL_I; // RULE7
		end
		if (wr_hit(wr_stb, bus_addr, OFS_FIXED_GAIN)) begin
			dgain_d = bus_wdata[DGAIN_LSB +: 3]; // RULE8
			cgain_d = bus_wdata[CGAIN_LSB +: 2]; // RULE9
		end
		if (wr_hit(wr_stb, bus_addr, OFS_VER_LOAD)) begin
			load_d = bus_wdata[LOAD_LSB +: 4]; // RULE11
		end
	end

	// lane-driven bits follow hardware every cycle; host writes never land
	always_comb begin
		sync_d = LANE_SYNC_I; // RULE10 RULE18
		mism_d = LANE_MISMATCH_I; // RULE13 RULE18
		search_d = LANE_SEARCH_I; // RULE14
	end

	always_comb begin
		a_term_d = a_term_q;
		a_tap_d = a_tap_q;
		a_dsw_d = a_dsw_q;
		a_csw_d = a_csw_q;
		a_dgain_d = a_dgain_q;
		a_cgain_d = a_cgain_q;
		a_adapt_d = a_adapt_q;
		if (commit) begin
			a_term_d = term_q; // RULE15
			a_tap_d = tap_q;
			a_dsw_d = dswing_q;
			a_csw_d = cswing_q;
			a_adapt_d = adapt_q;
			// fixed gain only reaches the lanes when adaptive is off
			a_dgain_d = adapt_q ? DGAIN_RST : dgain_q; // RULE16
			a_cgain_d = adapt_q ? CGAIN_RST : cgain_q; // RULE16
		end
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			adapt_q <= ADAPT_RST;
			term_q <= TERM_RST;
			speed_q <= SPEED_RST;
			dswing_q <= DSWING_RST;
			cswing_q <= CSWING_RST;
			tap_q <= TAP_RST;
			dgain_q <= DGAIN_RST;
			cgain_q <= CGAIN_RST;
			load_q <= LANE_RST;
			sync_q <= LANE_RST;
			mism_q <= LANE_RST;
			search_q <= LANE_RST;
		end else begin
			adapt_q <= adapt_d;
			term_q <= term_d;
			speed_q <= speed_d;
			dswing_q <= dswing_d;
			cswing_q <= cswing_d;
			tap_q <= tap_d;
			dgain_q <= dgain_d;
			cgain_q <= cgain_d;
			load_q <= load_d;
			sync_q <= sync_d;
			mism_q <= mism_d;
			search_q <= search_d;
		end
	end

	always_ff @(posedge CLK_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			a_term_q <= TERM_RST;
			a_tap_q <= TAP_RST;
			a_dsw_q <= DSWING_RST;
			a_csw_q <= CSWING_RST;
			a_dgain_q <= DGAIN_RST;
			a_cgain_q <= CGAIN_RST;
			a_adapt_q <= ADAPT_RST;
		end else begin
			a_term_q <= a_term_d;
			a_tap_q <= a_tap_d;
			a_dsw_q <= a_dsw_d;
			a_csw_q <= a_csw_d;
			a_dgain_q <= a_dgain_d;
			a_cgain_q <= a_cgain_d;
			a_adapt_q <= a_adapt_d;
		end
	end

	// bridge speed is not part of the commit set and acts at once
	assign BRIDGE_SPEED_O = speed_q; // RULE2
	assign TX_TERM_O = a_term_q;
	assign TAP_WEIGHT_O = a_tap_q;
	assign DATA_SWING_O = a_dsw_q;
	assign CLOCK_SWING_O = a_csw_q;
	assign DATA_GAIN_O = a_dgain_q;
	assign CLOCK_GAIN_O = a_cgain_q;
	assign ADAPTIVE_GAIN_O = a_adapt_q;

	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (!RESETN_I);

	a_term_gated: assert property ( // RULE7
		wr_hit(wr_stb, bus_addr, OFS_LINK_MISC) && !CFG_EN_I |=> term_q == $past(term_q))
		else $error("termination changed while configuration disabled");
	a_term_write: assert property ( // RULE1
		wr_hit(wr_stb, bus_addr, OFS_LINK_MISC) && CFG_EN_I |=> term_q == $past(bus_wdata[4:3]))
		else $error("termination write not stored");
	a_speed_write: assert property ( // RULE2
		wr_hit(wr_stb, bus_addr, OFS_LINK_MISC) |=> BRIDGE_SPEED_O == $past(bus_wdata[2]))
		else $error("bridge speed not taken from write");
	a_tap_strap: assert property ( // RULE7
		!CFG_EN_I ##1 !CFG_EN_I |-> TAP_WEIGHT_O == $past(TAP_WEIGHT_O) || $past(commit))
		else $error("tap output moved without commit");
	a_commit_take: assert property ( // RULE15
		commit |=> DATA_SWING_O == $past(dswing_q) && TX_TERM_O == $past(term_q))
		else $error("commit did not apply stored values");
	a_commit_hold: assert property ( // RULE15
		!commit |=> $stable(DATA_SWING_O) && $stable(CLOCK_SWING_O) && $stable(TX_TERM_O))
		else $error("lane values changed without commit");
	a_gain_adapt: assert property ( // RULE16
		ADAPTIVE_GAIN_O |-> DATA_GAIN_O == 3'h0 && CLOCK_GAIN_O == 2'h0)
		else $error("fixed gain driven in adaptive mode");
	a_rsvd_bit0: assert property ( // RULE17
		bus_addr == OFS_FIXED_GAIN |-> bus_rdata[7:6] == 2'h0 && bus_rdata[0])
		else $error("equalizer reserved bits wrong");
	a_status_track: assert property ( // RULE13
		##1 mism_q == $past(LANE_MISMATCH_I) && search_q == $past(LANE_SEARCH_I))
		else $error("status bits do not follow lanes");
	a_lane_hold: assert property ( // RULE12
		!load_q[0] |=> LANE_SETTINGS_O[VSET_W-1:0] == $past(LANE_SETTINGS_O[VSET_W-1:0]))
		else $error("lane 0 settings changed while not loading");
	a_lane_pass: assert property ( // RULE11
		load_q[2] |=> LANE_SETTINGS_O[3*VSET_W-1:2*VSET_W] == $past(VERIFIER_SETTINGS_I))
		else $error("lane 2 did not take settings");

	c_commit: cover property (commit);
	c_cfg_write: cover property (wr_hit(wr_stb, bus_addr, OFS_SWING_TAP) && CFG_EN_I);
	c_load_fall: cover property (load_q[0] ##1 !load_q[0]);
	c_fixed_mode: cover property (commit && !adapt_q);
endmodule

/* File: verif/rlt_host_model.sv */
module rlt_host_model
	import rlt_pkg::*;
(
	// clock
	input wire logic CLK_I,
	// two-wire lines, sda released = 1
	output logic scl_o,
	output logic sda_o,
	input wire logic sda_i
);
	timeunit 1ns;
	timeprecision 1ps;

	// bus stands idle high outside frames
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end

	// four cycles a phase keeps well above the two-cycle minimum
	task automatic half();
		repeat (4) @(posedge CLK_I);
	endtask

	// data moves only while scl is low
	task automatic bitx(input logic b, output logic r);
		@(posedge CLK_I);
		sda_o <= b;
		half();
		scl_o <= 1'b1;
		half();
		r = sda_i;
		scl_o <= 1'b0;
	endtask

	task automatic start();
		@(posedge CLK_I);
		sda_o <= 1'b1;
		half();
		scl_o <= 1'b1;
		half();
		sda_o <= 1'b0;
		half();
		scl_o <= 1'b0;
	endtask

	task automatic stop();
		@(posedge CLK_I);
		sda_o <= 1'b0;
		half();
		scl_o <= 1'b1;
		half();
		sda_o <= 1'b1;
		half();
	endtask

	task automatic wbyte(input logic [7:0] b, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(b[i], r);
		end
		bitx(1'b1, r);
		ack = ~r;
	endtask

	task automatic rbyte(input logic last, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, r);
			b[i] = r;
		end
		bitx(last, r);
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
		logic k0;
		logic k1;
		logic k2;
		start();
		wbyte({DEV_ADDR, 1'b0}, k0);
		wbyte(a, k1);
		wbyte(d, k2);
		stop();
		ok = k0 & k1 & k2;
	endtask

	// pointer set by a write, then repeated start for the read
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic k;
		start();
		wbyte({DEV_ADDR, 1'b0}, k);
		wbyte(a, k);
		start();
		wbyte({DEV_ADDR, 1'b1}, k);
		rbyte(1'b1, d);
		stop();
	endtask
endmodule

/* File: verif/testbench.sv */
module testbench
	import rlt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic clk, rst_n, cfg_en, scl, sda_h, sda_w, sda_o, sda_oe, spd, adapt, ack;
	logic [1:0] pre_sel, term, tap, cgain;
	logic [2:0] dsw, csw, dgain;
	logic [3:0] sync, mism, search;
	logic [31:0] vset;
	logic [127:0] lanes;
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;

	// open drain: either party pulls low, pull-up otherwise
	assign sda_w = sda_h & (sda_oe ? sda_o : 1'b1);

	rlt_csr_top rlt_csr_top_inst (
		.CLK_I(clk), .RESETN_I(rst_n), .SCL_I(scl), .SDA_I(sda_w), .SDA_O(sda_o),
		.SDA_OE_O(sda_oe), .CFG_EN_I(cfg_en), .PRE_SEL_I(pre_sel), .LANE_SYNC_I(sync),
		.LANE_MISMATCH_I(mism), .LANE_SEARCH_I(search), .VERIFIER_SETTINGS_I(vset),
		.LANE_SETTINGS_O(lanes), .TX_TERM_O(term), .BRIDGE_SPEED_O(spd),
		.DATA_SWING_O(dsw), .CLOCK_SWING_O(csw), .TAP_WEIGHT_O(tap),
		.ADAPTIVE_GAIN_O(adapt), .DATA_GAIN_O(dgain), .CLOCK_GAIN_O(cgain)
	);

	rlt_host_model rlt_host_model_inst (.CLK_I(clk), .scl_o(scl), .sda_o(sda_h), .sda_i(sda_w));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// whole run needs some 11k cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			num_errors++;
			print_verdict();
		end
	end

	task automatic chk_port(input logic [127:0] got, input logic [127:0] exp);
		#1;
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] got;
		rlt_host_model_inst.rd(a, got);
		chk_port({120'h0, got}, {120'h0, exp});
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic ok;
		rlt_host_model_inst.wr(a, d, ok);
		chk_port({127'h0, ok}, 128'h1);
	endtask

	function automatic logic [127:0] tune(input logic [16:0] v);
		return {111'h0, v};
	endfunction

	function automatic logic [16:0] now();
		return {term, spd, dsw, csw, tap, adapt, dgain, cgain};
	endfunction

	task automatic t_reset();
		chk_port(tune(now()), tune({2'h0, 1'b0, 3'h0, 3'h0, 2'h0, 1'b1, 3'h0, 2'h0}));
		chk_reg(8'h0A, 8'h20);
		chk_reg(8'h0B, 8'h00);
		chk_reg(8'h0C, 8'h00);
		chk_reg(8'h0D, 8'h01);
		chk_reg(8'h0E, 8'h00);
		chk_reg(8'h0F, 8'h00);
		chk_reg(8'h20, 8'h00);
		rlt_host_model_inst.start();
		rlt_host_model_inst.wbyte({DEV_ADDR ^ 7'h01, 1'b0}, ack);
		rlt_host_model_inst.stop();
		chk_port({127'h0, ack}, 128'h0);
		$display("test reset done");
	endtask

	task automatic t_commit();
		wr(8'h0B, 8'h08);
		wr(8'h0C, 8'hA5);
		wr(8'h0D, 8'hFF);
		chk_reg(8'h0D, 8'h3F);
		chk_reg(8'h0C, 8'hA5);
		chk_port(tune(now()), tune({2'h0, 1'b0, 3'h0, 3'h0, 2'h0, 1'b1, 3'h0, 2'h0}));
		wr(8'h0A, 8'h00);
		wr(8'h0A, 8'h04);
		chk_port(tune(now()), tune({2'h1, 1'b0, 3'h5, 3'h1, 2'h1, 1'b0, 3'h7, 2'h3}));
		chk_reg(8'h0A, 8'h00);
		wr(8'h0A, 8'h20);
		wr(8'h0A, 8'h24);
		chk_port(tune(now()), tune({2'h1, 1'b0, 3'h5, 3'h1, 2'h1, 1'b1, 3'h0, 2'h0}));
		chk_reg(8'h0A, 8'h20);
		$display("test commit done");
	endtask

	task automatic t_speed();
		// sleep inhibit sits outside this bank, so the write is dropped
		wr(8'h09, 8'h04);
		chk_reg(8'h09, 8'h00);
		wr(8'h0B, 8'h0C);
		chk_port({127'h0, spd}, 128'h1);
		chk_reg(8'h0B, 8'h0C);
		wr(8'h0B, 8'h08);
		chk_port({127'h0, spd}, 128'h0);
		$display("test speed done");
	endtask

	task automatic t_cfg();
		@(posedge clk);
		cfg_en <= 1'b0;
		pre_sel <= 2'h2;
		wr(8'h0B, 8'h10);
		chk_reg(8'h0B, 8'h08);
		wr(8'h0C, 8'h01);
		chk_reg(8'h0C, 8'h02);
		wr(8'h0A, 8'h04);
		chk_reg(8'h0A, 8'h20);
		chk_port(tune(now()), tune({2'h1, 1'b0, 3'h0, 3'h0, 2'h2, 1'b1, 3'h0, 2'h0}));
		@(posedge clk);
		cfg_en <= 1'b1;
		$display("test config gate done");
	endtask

	task automatic t_lane();
		@(posedge clk);
		vset <= 32'h1111_1111;
		sync <= 4'hA;
		mism <= 4'h5;
		search <= 4'h3;
		wr(8'h0E, 8'h05);
		chk_port(lanes, {32'h0, 32'h1111_1111, 32'h0, 32'h1111_1111});
		@(posedge clk);
		vset <= 32'h2222_2222;
		repeat (3) @(posedge clk);
		chk_port(lanes, {32'h0, 32'h2222_2222, 32'h0, 32'h2222_2222});
		wr(8'h0E, 8'hF0);
		chk_reg(8'h0E, 8'hA0);
		@(posedge clk);
		vset <= 32'h3333_3333;
		repeat (3) @(posedge clk);
		chk_port(lanes, {32'h0, 32'h2222_2222, 32'h0, 32'h2222_2222});
		chk_reg(8'h0F, 8'h53);
		wr(8'h0F, 8'h00);
		chk_reg(8'h0F, 8'h53);
		$display("test lanes done");
	endtask

	initial begin
		rst_n = 1'b0;
		cfg_en = 1'b1;
		pre_sel = 2'h0;
		sync = 4'h0;
		mism = 4'h0;
		search = 4'h0;
		vset = 32'h0;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset();
		t_commit();
		t_speed();
		t_cfg();
		t_lane();
		print_verdict();
	end
endmodule
